// ### rtl/dma_pkg.sv
// Purpose: shared constants for the four-channel dma controller
// Assumes: apb register access, 32-bit data, one word per register index
// Notes:   byte address = 4 * index; channel stride is 0x20 indices
package dma_pkg;
    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int CH_NUM = 4;
    localparam int ADDR_W = 24;
    localparam int LEN_W = 16;
    localparam int CTRL_W = 17;
    localparam int PADDR_W = 12;

    // ----------------------------------------------------------------
    // register indices within one channel
    // ----------------------------------------------------------------
    localparam logic [4:0] IDX_ADDR_A = 5'h00;
    localparam logic [4:0] IDX_ADDR_B = 5'h08;
    localparam logic [4:0] IDX_LEN = 5'h10;
    localparam logic [4:0] IDX_CTRL = 5'h1c;
    localparam logic [4:0] IDX_STAT = 5'h1e;

    // ----------------------------------------------------------------
    // channel control register fields
    // ----------------------------------------------------------------
    localparam int C_ENABLE = 0;
    localparam int C_SIZE16 = 1;
    localparam int C_WAY = 2;
    localparam int C_INDIRECT = 3;
    localparam int C_CONT = 4;
    localparam int C_ADJ_A = 5;
    localparam int C_ADJ_B = 6;
    localparam int C_DEC_A = 7;
    localparam int C_DEC_B = 8;
    localparam int C_STEP_A = 9;
    localparam int C_STEP_B = 11;
    localparam int C_AUTO_INIT = 13;
    localparam int C_TC_IRQ_EN = 14;
    localparam int C_OVR_IRQ_EN = 15;
    localparam int C_SW_REQ = 16;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 17'h00000;

    // ----------------------------------------------------------------
    // channel status register fields
    // ----------------------------------------------------------------
    localparam int S_TC = 0;
    localparam int S_OVR = 1;
    localparam int S_ACTIVE = 2;
    localparam int S_VALID = 3;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_ARB = 7'b0000010,
        ST_PRIO = 7'b0000100,
        ST_CYC1 = 7'b0001000,
        ST_CYC2 = 7'b0010000,
        ST_UPD = 7'b0100000,
        ST_REL = 7'b1000000
    } seq_state_t;
endpackage

// ### rtl/four_channel_dma_controller.sv
// Purpose: four-channel dma controller, cpu bus master, apb programmed
// Assumes: requests, grant and bus ready come from logic on clk
// Notes:   single-transfer and continuous modes; one bus cycle in flight at a time
`timescale 1ns/1ps
`default_nettype none
module four_channel_dma_controller
    import dma_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic [dma_pkg::PADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // on-chip peripheral requests and acknowledges
    input wire logic [dma_pkg::CH_NUM-1:0] transferRequest,
    output logic [dma_pkg::CH_NUM-1:0] transferAck,
    // cpu bus mastership
    output logic busRequest,
    input wire logic busGrant,
    // cpu bus data cycle
    output logic busValid,
    output logic [dma_pkg::ADDR_W-1:0] busAddr,
    output logic busWrite,
    output logic busWide,
    output logic busFlyby,
    output logic [15:0] busWdata,
    input wire logic [15:0] busRdata,
    input wire logic busReady,
    // per-channel interrupt levels
    output logic [dma_pkg::CH_NUM-1:0] chanIrq
);
    import dma_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [ADDR_W-1:0] addrA_reg [CH_NUM];
    logic [ADDR_W-1:0] addrA_next [CH_NUM];
    logic [ADDR_W-1:0] addrB_reg [CH_NUM];
    logic [ADDR_W-1:0] addrB_next [CH_NUM];
    logic [LEN_W-1:0] len_reg [CH_NUM];
    logic [LEN_W-1:0] len_next [CH_NUM];
    logic [CTRL_W-1:0] ctrl_reg [CH_NUM];
    logic [CTRL_W-1:0] ctrl_next [CH_NUM];
    logic [CH_NUM-1:0] tc_reg, tc_next;
    logic [CH_NUM-1:0] ovr_reg, ovr_next;
    logic [CH_NUM-1:0] act_reg, act_next;
    logic [CH_NUM-1:0] vld_reg, vld_next;
    seq_state_t state_reg, state_next;
    logic [1:0] cur_reg, cur_next;
    logic [31:0] prdata_reg, prdata_next;
    logic slverr_reg, slverr_next;
    logic busReq_reg, busReq_next;
    logic busValid_reg, busValid_next;
    logic [ADDR_W-1:0] busAddr_reg, busAddr_next;
    logic busWrite_reg, busWrite_next;
    logic busWide_reg, busWide_next;
    logic busFlyby_reg, busFlyby_next;
    logic [15:0] busWdata_reg, busWdata_next;
    logic [CH_NUM-1:0] ack_reg, ack_next;

    // ----------------------------------------------------------------
    // decode and helpers
    // ----------------------------------------------------------------
    logic [1:0] regCh;
    logic [4:0] regIdx;
    logic mapped;
    logic apbWr;
    logic [CH_NUM-1:0] serviceable;
    logic anyServ;
    logic [1:0] winner;

    assign regCh = paddr[8:7];
    assign regIdx = paddr[6:2];
    assign mapped = (paddr[PADDR_W-1:9] == '0) && (paddr[1:0] == 2'b00) &&
        (regIdx == IDX_ADDR_A || regIdx == IDX_ADDR_B || regIdx == IDX_LEN ||
         regIdx == IDX_CTRL || regIdx == IDX_STAT);
    assign apbWr = psel && penable && pwrite && mapped;

    // only on-chip request lines or the software bit start a channel
    always_comb begin
        for (int i = 0; i < CH_NUM; i++) begin
            serviceable[i] = ctrl_reg[i][C_ENABLE] && act_reg[i] &&
                (transferRequest[i] || ctrl_reg[i][C_SW_REQ]);
        end
    end
    assign anyServ = |serviceable;

    // lowest index wins; evaluated in the cycle before the bus cycle
    always_comb begin
        winner = 2'd0;
        for (int i = CH_NUM - 1; i >= 0; i--) begin
            if (serviceable[i]) begin
                winner = 2'(i);
            end
        end
    end

    // step in bytes as a 24-bit value: 1, 2, 4 or 8
    function automatic logic [ADDR_W-1:0] stepOf(input logic [1:0] sel);
        stepOf = ADDR_W'(1) << sel;
    endfunction

    // address counter update: hold, increment or decrement
    function automatic logic [ADDR_W-1:0] adjust(input logic [ADDR_W-1:0] a,
        input logic en, input logic dec, input logic [1:0] sel);
        if (!en) begin
            adjust = a;
        end else if (dec) begin
            adjust = a - stepOf(sel);
        end else begin
            adjust = a + stepOf(sel);
        end
    endfunction

    // ----------------------------------------------------------------
    // next-state logic: sequencer, channel registers and apb
    // ----------------------------------------------------------------
    // hardware updates are applied first so apb writes to counters land
    // last, while status flags let a hardware set beat a software clear
    always_comb begin
        logic [CTRL_W-1:0] c;
        logic lastItem;
        c = ctrl_reg[cur_reg];
        lastItem = (len_reg[cur_reg] == LEN_W'(1)) || (len_reg[cur_reg] == '0);
        addrA_next = addrA_reg;
        addrB_next = addrB_reg;
        len_next = len_reg;
        ctrl_next = ctrl_reg;
        tc_next = tc_reg;
        ovr_next = ovr_reg;
        act_next = act_reg;
        vld_next = vld_reg;
        state_next = state_reg;
        cur_next = cur_reg;
        busReq_next = busReq_reg;
        busValid_next = busValid_reg;
        busAddr_next = busAddr_reg;
        busWrite_next = busWrite_reg;
        busWide_next = busWide_reg;
        busFlyby_next = busFlyby_reg;
        busWdata_next = busWdata_reg;
        ack_next = ack_reg;
        prdata_next = prdata_reg;
        slverr_next = slverr_reg;

        // software status clears come before hardware sets
        if (apbWr && regIdx == IDX_STAT) begin
            if (pwdata[S_TC]) tc_next[regCh] = 1'b0;
            if (pwdata[S_OVR]) ovr_next[regCh] = 1'b0;
            if (pwdata[S_VALID]) vld_next[regCh] = 1'b0;
        end

        case (state_reg)
            ST_IDLE: begin
                if (anyServ) begin
                    busReq_next = 1'b1;
                    state_next = ST_ARB;
                end
            end
            ST_ARB: begin
                // no data cycle until the cpu hands over the bus
                if (busGrant) begin
                    state_next = ST_PRIO;
                end
            end
            ST_PRIO: begin
                // one clock before the first bus clock: pick and load cycle
                if (anyServ) begin
                    c = ctrl_reg[winner];
                    cur_next = winner;
                    busValid_next = 1'b1;
                    busWide_next = c[C_SIZE16];
                    busWdata_next = 16'h0000;
                    if (!c[C_INDIRECT]) begin
                        // flyby: one address, implied device holds the data
                        busAddr_next = addrA_reg[winner];
                        busWrite_next = c[C_WAY];
                        busFlyby_next = 1'b1;
                        ack_next[winner] = !c[C_SW_REQ];
                    end else begin
                        busAddr_next = c[C_WAY] ? addrB_reg[winner] :
                            addrA_reg[winner];
                        busWrite_next = 1'b0;
                        busFlyby_next = 1'b0;
                        ack_next[winner] = !c[C_SW_REQ] && !c[C_WAY];
                    end
                    state_next = ST_CYC1;
                end else begin
                    busReq_next = 1'b0;
                    state_next = ST_REL;
                end
            end
            ST_CYC1: begin
                if (busReady) begin
                    busValid_next = 1'b0;
                    ack_next = '0;
                    if (c[C_INDIRECT]) begin
                        // write data register doubles as the holding register
                        busValid_next = 1'b1;
                        busWrite_next = 1'b1;
                        busWdata_next = busRdata;
                        busAddr_next = c[C_WAY] ? addrA_reg[cur_reg] :
                            addrB_reg[cur_reg];
                        ack_next[cur_reg] = !c[C_SW_REQ] && c[C_WAY];
                        state_next = ST_CYC2;
                    end else begin
                        busFlyby_next = 1'b0;
                        state_next = ST_UPD;
                    end
                end
            end
            ST_CYC2: begin
                if (busReady) begin
                    busValid_next = 1'b0;
                    busWrite_next = 1'b0;
                    ack_next = '0;
                    state_next = ST_UPD;
                end
            end
            ST_UPD: begin
                // per-item counter update, independent of size and way
                len_next[cur_reg] = len_reg[cur_reg] - LEN_W'(1);
                addrA_next[cur_reg] = adjust(addrA_reg[cur_reg], c[C_ADJ_A],
                    c[C_DEC_A], c[C_STEP_A +: 2]);
                if (c[C_INDIRECT]) begin
                    addrB_next[cur_reg] = adjust(addrB_reg[cur_reg], c[C_ADJ_B],
                        c[C_DEC_B], c[C_STEP_B +: 2]);
                end
                if (lastItem) begin
                    // block done: status set in the same clock the bus goes back
                    len_next[cur_reg] = '0;
                    tc_next[cur_reg] = 1'b1;
                    ovr_next[cur_reg] = 1'b1;
                    act_next[cur_reg] = 1'b0;
                    busReq_next = 1'b0;
                    state_next = ST_REL;
                end else if (c[C_CONT] && serviceable[cur_reg]) begin
                    // request looked at now that acknowledge has dropped
                    state_next = ST_PRIO;
                end else begin
                    busReq_next = 1'b0;
                    state_next = ST_REL;
                end
            end
            ST_REL: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
                busReq_next = 1'b0;
                busValid_next = 1'b0;
                ack_next = '0;
            end
        endcase

        // apb writes to counters and control
        if (apbWr) begin
            case (regIdx)
                IDX_ADDR_A: addrA_next[regCh] = pwdata[ADDR_W-1:0];
                IDX_ADDR_B: addrB_next[regCh] = pwdata[ADDR_W-1:0];
                IDX_LEN: len_next[regCh] = pwdata[LEN_W-1:0];
                IDX_CTRL: begin
                    ctrl_next[regCh] = pwdata[CTRL_W-1:0];
                    // enabling arms the channel; it stays armed until done
                    if (pwdata[C_ENABLE] && !ctrl_reg[regCh][C_ENABLE]) begin
                        act_next[regCh] = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // read data and error captured in the setup phase
        if (psel && !penable) begin
            slverr_next = !mapped;
            case (regIdx)
                IDX_ADDR_A: prdata_next = {8'h00, addrA_reg[regCh]};
                IDX_ADDR_B: prdata_next = {8'h00, addrB_reg[regCh]};
                IDX_LEN: prdata_next = {16'h0000, len_reg[regCh]};
                IDX_CTRL: prdata_next = {15'h0000, ctrl_reg[regCh]};
                IDX_STAT: prdata_next = {28'h0000000, vld_reg[regCh],
                    act_reg[regCh], ovr_reg[regCh], tc_reg[regCh]};
                default: prdata_next = 32'h00000000;
            endcase
            if (!mapped) begin
                prdata_next = 32'h00000000;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < CH_NUM; i++) begin
                addrA_reg[i] <= '0;
                addrB_reg[i] <= '0;
                len_reg[i] <= '0;
                ctrl_reg[i] <= CTRL_RESET;
            end
            tc_reg <= '0;
            ovr_reg <= '0;
            act_reg <= '0;
            vld_reg <= '0;
            state_reg <= ST_IDLE;
            cur_reg <= 2'd0;
            prdata_reg <= 32'h00000000;
            slverr_reg <= 1'b0;
            busReq_reg <= 1'b0;
            busValid_reg <= 1'b0;
            busAddr_reg <= '0;
            busWrite_reg <= 1'b0;
            busWide_reg <= 1'b0;
            busFlyby_reg <= 1'b0;
            busWdata_reg <= 16'h0000;
            ack_reg <= '0;
        end else begin
            addrA_reg <= addrA_next;
            addrB_reg <= addrB_next;
            len_reg <= len_next;
            ctrl_reg <= ctrl_next;
            tc_reg <= tc_next;
            ovr_reg <= ovr_next;
            act_reg <= act_next;
            vld_reg <= vld_next;
            state_reg <= state_next;
            cur_reg <= cur_next;
            prdata_reg <= prdata_next;
            slverr_reg <= slverr_next;
            busReq_reg <= busReq_next;
            busValid_reg <= busValid_next;
            busAddr_reg <= busAddr_next;
            busWrite_reg <= busWrite_next;
            busWide_reg <= busWide_next;
            busFlyby_reg <= busFlyby_next;
            busWdata_reg <= busWdata_next;
            ack_reg <= ack_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // zero-wait apb: every access completes in its first access cycle
    assign pready = 1'b1;
    assign prdata = prdata_reg;
    assign pslverr = slverr_reg && psel && penable;
    assign busRequest = busReq_reg;
    assign busValid = busValid_reg;
    assign busAddr = busAddr_reg;
    assign busWrite = busWrite_reg;
    assign busWide = busWide_reg;
    assign busFlyby = busFlyby_reg;
    assign busWdata = busWdata_reg;
    assign transferAck = ack_reg;

    // interrupt levels follow the flags and their enables
    always_comb begin
        for (int i = 0; i < CH_NUM; i++) begin
            chanIrq[i] = (tc_reg[i] && ctrl_reg[i][C_TC_IRQ_EN]) ||
                (ovr_reg[i] && ctrl_reg[i][C_OVR_IRQ_EN]);
        end
    end
endmodule // four_channel_dma_controller
`default_nettype wire

// ### dv/dma_props.sv
// Purpose: port-level checks on the dma controller
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to every controller instance, see foot of file
`timescale 1ns/1ps
`default_nettype none
module dma_props
    import dma_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // cpu bus and acknowledges
    input wire logic [dma_pkg::CH_NUM-1:0] transferAck,
    input wire logic busRequest,
    input wire logic busGrant,
    input wire logic busValid,
    input wire logic [dma_pkg::ADDR_W-1:0] busAddr,
    input wire logic busWrite,
    input wire logic busFlyby,
    input wire logic busReady,
    input wire logic [dma_pkg::CH_NUM-1:0] chanIrq
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // one cycle per direct item and one channel at a time
    a_ack_in_cycle: assert property (|transferAck |-> busValid)
        else $error("ack outside a bus cycle");
    a_ack_onehot: assert property ($onehot0(transferAck))
        else $error("two channels acknowledged");
    a_grant_first: assert property ($rose(busValid) |-> $past(busGrant, 2) && busRequest)
        else $error("bus cycle without grant");
    a_cycle_holds: assert property (busValid && !busReady |=> busValid && $stable(busAddr))
        else $error("bus cycle dropped early");
    a_master_only: assert property (busValid |-> busRequest)
        else $error("bus cycle while not master");
    a_read_then_write: assert property (busValid && busReady && !busFlyby && !busWrite
        |=> ##[0:2] (busValid && busWrite))
        else $error("indirect read not followed by write");
    a_release_idle: assert property ($fell(busRequest) |-> !busValid)
        else $error("bus released mid cycle");
    a_flyby_single: assert property (busValid && busFlyby && busReady |=> !busValid)
        else $error("direct item took two cycles");
    a_direct_rate: assert property (busValid && busFlyby && busReady
        |=> !busValid ##1 !busValid)
        else $error("direct items closer than three clocks");
    a_indirect_rate: assert property (busValid && busWrite && !busFlyby && busReady
        |=> !busValid)
        else $error("indirect items closer than two clocks");

    // main scenarios reached
    cover property (busValid && busReady && transferAck[0]);
    cover property (busValid && busWrite && !busFlyby);
    cover property ($rose(|chanIrq));
endmodule // dma_props

bind four_channel_dma_controller dma_props chk (.clk, .sys_rst, .transferAck, .busRequest,
    .busGrant, .busValid, .busAddr, .busWrite, .busFlyby, .busReady, .chanIrq);
`default_nettype wire

// ### dv/cpu_bus_model.sv
// Purpose: cpu bus arbiter and memory answering the dma master
// Assumes: same clock as the controller
// Notes:   slow adds two waits to grant and to each bus cycle
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
    // clock, reset, pacing
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic slow,
    // master side
    input wire logic busRequest,
    input wire logic busValid,
    input wire logic [23:0] busAddr,
    // answers
    output logic busGrant,
    output logic busReady,
    output logic [15:0] busRdata
);
    logic [1:0] waitReg, waitNext, lim;
    logic grantNext;
    logic [15:0] memWord;

    // wait counter runs while a grant or a cycle is pending
    always_comb begin
        lim = slow ? 2'h2 : 2'h0;
        waitNext = 2'h0;
        if ((busRequest && !busGrant) || (busValid && !busReady)) begin
            waitNext = waitReg + 2'h1;
        end
        grantNext = busRequest && (busGrant || waitReg >= lim);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            waitReg <= 2'h0;
            busGrant <= 1'b0;
        end else begin
            waitReg <= waitNext;
            busGrant <= grantNext;
        end
    end

    // data outside the ready cycle is inverted so stale values never pass
    assign memWord = busAddr[15:0] ^ 16'h5a5a;
    assign busReady = busValid && waitReg >= lim;
    assign busRdata = busReady ? memWord : ~memWord;
endmodule // cpu_bus_model
`default_nettype wire

// ### dv/tb.sv
// Purpose: self-checking bench for the dma controller
// Assumes: memory word at an address is address xor 5a5a
// Notes:   each scenario is a task that judges its own results
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dma_pkg::*;
    logic clk, sys_rst, psel, penable, pwrite, slow, pready, pslverr;
    logic busRequest, busGrant, busValid, busWrite, busWide, busFlyby, busReady;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] transferRequest, transferAck, chanIrq;
    logic [23:0] busAddr;
    logic [15:0] busWdata, busRdata;
    logic [46:0] cycQ[$];
    int n_fail, comparisons, cycles, relCnt;

    four_channel_dma_controller dut (.clk, .sys_rst, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .transferRequest, .transferAck, .busRequest,
        .busGrant, .busValid, .busAddr, .busWrite, .busWide, .busFlyby, .busWdata,
        .busRdata, .busReady, .chanIrq);
    cpu_bus_model farSide (.clk, .sys_rst, .slow, .busRequest, .busValid, .busAddr,
        .busGrant, .busReady, .busRdata);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // monitor, timeout and helpers
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (busValid === 1'b1 && busReady === 1'b1) begin
            cycQ.push_back({transferAck, busFlyby, busWrite, busWide, busAddr,
                busWrite ? busWdata : 16'h0});
        end
        if ($fell(busRequest)) begin
            relCnt++;
        end
        if (cycles == 20000) begin
            n_fail++;
            test_done();
        end
    end

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; idle edge after it keeps strobes from toggling twice
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    function automatic logic [11:0] ra(input logic [1:0] ch, input logic [4:0] idx);
        return {3'h0, ch, idx, 2'h0};
    endfunction

    task automatic wr(input logic [1:0] ch, input logic [4:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, ra(ch, idx), d, r, e);
    endtask

    task automatic rd(input logic [1:0] ch, input logic [4:0] idx, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, ra(ch, idx), 32'h0, r, e);
        chk({e, r}, {1'b0, x});
    endtask

    // enable cleared first so the old setting cannot start early
    task automatic setup(input logic [1:0] ch, input logic [23:0] a, input logic [23:0] b,
        input logic [15:0] len, input logic [16:0] ctl);
        wr(ch, IDX_CTRL, 32'h0);
        wr(ch, IDX_ADDR_A, {8'h0, a});
        wr(ch, IDX_ADDR_B, {8'h0, b});
        wr(ch, IDX_LEN, {16'h0, len});
        wr(ch, IDX_STAT, 32'hf);
        wr(ch, IDX_CTRL, {15'h0, ctl});
        cycQ.delete();
        relCnt = 0;
    endtask

    // returns once tc reads set; only the bench timeout ends a hung wait
    task automatic waitTc(input logic [1:0] ch);
        logic [31:0] r;
        logic e;
        r = 32'h0;
        while (r[S_TC] !== 1'b1) begin
            apb(1'b0, ra(ch, IDX_STAT), 32'h0, r, e);
        end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic checkReset();
        logic [31:0] r;
        logic e;
        rd(0, IDX_CTRL, 32'h0);
        rd(3, IDX_STAT, 32'h0);
        apb(1'b0, 12'h018, 32'h0, r, e);
        chk({e, r}, {1'b1, 32'h0});
        chk(chanIrq, 4'h0);
    endtask

    // ch2 direct, 16-bit, step a by 2, intermittent, tc irq, slow bus
    task automatic directRun();
        slow <= 1'b1;
        setup(2, 24'h000100, 24'h0, 16'h2, 17'h04223);
        repeat (8) @(posedge clk);
        chk(cycQ.size(), 0);
        transferRequest <= 4'h4;
        waitTc(2);
        transferRequest <= 4'h0;
        chk(cycQ.pop_front(), {4'h4, 3'b101, 24'h000100, 16'h0});
        chk(cycQ.pop_front(), {4'h4, 3'b101, 24'h000102, 16'h0});
        chk(relCnt, 2);
        rd(2, IDX_STAT, 32'h3);
        rd(2, IDX_LEN, 32'h0);
        chk(chanIrq, 4'h4);
    endtask

    // ch1 indirect, software request, continuous, way set, a and b step down
    task automatic indirectRun();
        slow <= 1'b0;
        setup(1, 24'h000200, 24'h000300, 16'h2, 17'h101fd);
        waitTc(1);
        chk(cycQ.pop_front(), {4'h0, 3'b000, 24'h000300, 16'h0});
        chk(cycQ.pop_front(), {4'h0, 3'b010, 24'h000200, 16'h595a});
        chk(cycQ.pop_front(), {4'h0, 3'b000, 24'h0002ff, 16'h0});
        chk(cycQ.pop_front(), {4'h0, 3'b010, 24'h0001ff, 16'h58a5});
        chk(relCnt, 1);
        rd(1, IDX_STAT, 32'h3);
    endtask

    // ch0 and ch3 requested together; ch0 must be served first
    task automatic prioRun();
        // ch3 indirect way 0 from its peripheral, ch0 direct write
        setup(3, 24'h000500, 24'h000600, 16'h1, 17'h08009);
        setup(0, 24'h000400, 24'h0, 16'h1, 17'h00005);
        transferRequest <= 4'h9;
        waitTc(3);
        transferRequest <= 4'h0;
        chk(cycQ.pop_front(), {4'h1, 3'b110, 24'h000400, 16'h0});
        chk(cycQ.pop_front(), {4'h8, 3'b000, 24'h000500, 16'h0});
        chk(cycQ.pop_front(), {4'h0, 3'b010, 24'h000600, 16'h5f5a});
        wr(2, IDX_STAT, 32'h3);
        rd(2, IDX_STAT, 32'h0);
        chk(chanIrq, 4'h8);
    endtask

    initial begin
        sys_rst = 1'b1;
        {psel, penable, pwrite, slow} = 4'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        transferRequest = 4'h0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        checkReset();
        directRun();
        indirectRun();
        prioRun();
        test_done();
    end
endmodule // tb
`default_nettype wire
